// File: design/float_to_int_store.sv
// Float-to-integer store unit: rounds, range-checks and answers overflow.
// Assumes the FP stack presents one operand per request and the store path takes
// the result in the cycle it is offered; status pulses are merged by the FPU.
//
// What this block does
// - Convert to signed 16, 32 or 64 bit integers with range checks each.
// - Support nearest, chop, down and up; overflow limits follow the mode.
// - Masked overflow stores integer indefinite, sign position set, rest clear.
// - Unmasked overflow suppresses the store and keeps the source on the stack.
// - Any overflow sets the invalid operation flag, whatever the mask.
// - Unmasked overflow raises a trap to the numeric exception handler.
// - 16-bit limits are the nearest and up intervals; outside means overflow.
// - 32-bit limits are the nearest and up intervals; outside means overflow.
// - Huge positive operands with all upper bits set overflow, never give zero.
// - Update the round-up condition bit and precision flag from actual rounding.
`timescale 1ns/100ps
`default_nettype none
module float_to_int_store
  import fist_pkg::*;
(
  input  wire logic           ref_clk,
  input  wire logic           rst_n,
  input  wire logic           req_valid,
  input  wire logic           op_sign,
  input  wire logic [14:0]    op_exponent,
  input  wire logic [63:0]    op_significand,
  input  wire round_mode_type round_mode,
  input  wire dest_width_type dest_width,
  input  wire logic           invalid_mask,
  output logic                done,
  output logic                store_valid,
  output logic [63:0]         store_data,
  output dest_width_type      store_width,
  output logic                keep_operand,
  output logic                invalid_operation_flag,
  output logic                precision_flag,
  output logic                roundup_wr,
  output logic                roundup_condition_bit,
  output logic                trap
);

  // Whole registered state of the unit.
  typedef struct packed {
    logic           done;
    logic           store_valid;
    logic [63:0]    store_data;
    dest_width_type store_width;
    logic           keep_operand;
    logic           inval_set;
    logic           inexact_set;
    logic           rup_wr;
    logic           rup_val;
    logic           trap;
  } unit_state_type;

  localparam unit_state_type STATE_RESET = '{
    done:         1'b0,
    store_valid:  1'b0,
    store_data:   64'h0,
    store_width:  DST_16,
    keep_operand: 1'b0,
    inval_set:    1'b0,
    inexact_set:  1'b0,
    rup_wr:       1'b0,
    rup_val:      1'b0,
    trap:         1'b0
  };

  unit_state_type state_reg;
  unit_state_type state_next;
  round_if        rnd ();
  logic [64:0]    limit;
  logic           overflow;
  logic [63:0]    twos;
  logic           trap_cause;

  // Operand fields go straight to the rounder; it is purely combinational.
  assign rnd.sign        = op_sign;
  assign rnd.exponent    = op_exponent;
  assign rnd.significand = op_significand;
  assign rnd.mode        = round_mode;

  round_align u_round (
    .rif (rnd.rounder)
  );

  // Checking the rounded magnitude makes the limits follow the mode for free:
  // a negative result may reach one more than a positive one.
  always_comb begin
    limit    = pos_limit(dest_width);
    overflow = rnd.huge
             || (!op_sign && rnd.magnitude > limit)
             || (op_sign && rnd.magnitude > (limit + 65'h1));
    twos     = op_sign ? (64'h0 - rnd.magnitude[63:0]) : rnd.magnitude[63:0];
  end

  // Next state: one answer per request, offered one cycle after it is taken.
  always_comb begin
    state_next = STATE_RESET;
    if (req_valid) begin
      state_next.done        = 1'b1;
      state_next.store_width = dest_width;
      if (overflow) begin
        state_next.inval_set = 1'b1;
        if (invalid_mask) begin
          state_next.store_valid = 1'b1;
          state_next.store_data  = indefinite(dest_width);
        end else begin
          state_next.keep_operand = 1'b1;
          state_next.trap         = 1'b1;
        end
        // Round-up bit is cleared on invalid, since no rounding result exists.
        state_next.rup_wr = 1'b1;
      end else begin
        state_next.store_valid = 1'b1;
        state_next.store_data  = twos & width_mask(dest_width);
        state_next.inexact_set = rnd.inexact;
        state_next.rup_wr      = 1'b1;
        state_next.rup_val     = rnd.rounded_up;
      end
    end
  end

  // State register.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // Every output comes from the state register.
  assign done                   = state_reg.done;
  assign store_valid            = state_reg.store_valid;
  assign store_data             = state_reg.store_data;
  assign store_width            = state_reg.store_width;
  assign keep_operand           = state_reg.keep_operand;
  assign invalid_operation_flag = state_reg.inval_set;
  assign precision_flag         = state_reg.inexact_set;
  assign roundup_wr             = state_reg.rup_wr;
  assign roundup_condition_bit  = state_reg.rup_val;
  assign trap                   = state_reg.trap;

  // A request that must trap; named so the checks can look one cycle back at it.
  assign trap_cause = req_valid && overflow && !invalid_mask;

  // Checks tie each answer to the request that caused it one cycle earlier.
  property p_indef_masked;
    @(posedge ref_clk) disable iff (!rst_n)
      (req_valid && overflow && invalid_mask)
      |=> (store_valid && store_data == indefinite($past(dest_width)));
  endproperty
  a_indef_masked: assert property (p_indef_masked)
    else $error("Masked overflow did not store the indefinite value.");

  property p_suppress;
    @(posedge ref_clk) disable iff (!rst_n)
      (req_valid && overflow && !invalid_mask) |=> (!store_valid && keep_operand);
  endproperty
  a_suppress: assert property (p_suppress)
    else $error("Unmasked overflow did not suppress the store.");

  property p_ie_on_overflow;
    @(posedge ref_clk) disable iff (!rst_n)
      req_valid |=> (invalid_operation_flag == $past(overflow));
  endproperty
  a_ie_on_overflow: assert property (p_ie_on_overflow)
    else $error("Invalid flag does not match overflow.");

  property p_trap;
    @(posedge ref_clk) disable iff (!rst_n)
      trap |-> ($past(req_valid) && $past(overflow) && !$past(invalid_mask));
  endproperty
  a_trap: assert property (p_trap)
    else $error("Trap without an unmasked overflow.");

  property p_trap_raised;
    @(posedge ref_clk) disable iff (!rst_n)
      trap_cause |=> trap ##1 (trap == $past(trap_cause));
  endproperty
  a_trap_raised: assert property (p_trap_raised)
    else $error("Unmasked overflow did not pulse the trap.");

  property p_range16;
    @(posedge ref_clk) disable iff (!rst_n)
      (req_valid && dest_width == DST_16 && !overflow)
      |=> (store_data[63:16] == 48'h0
           && store_data[15] == ($past(op_sign) && store_data[15:0] != 16'h0));
  endproperty
  a_range16: assert property (p_range16)
    else $error("16-bit store spilled above its width.");

  property p_huge_nonzero;
    @(posedge ref_clk) disable iff (!rst_n)
      (req_valid && !op_sign && rnd.magnitude > pos_limit(dest_width))
      |=> (invalid_operation_flag && (!store_valid || store_data != 64'h0));
  endproperty
  a_huge_nonzero: assert property (p_huge_nonzero)
    else $error("Overflowing positive operand stored zero.");

  property p_status;
    @(posedge ref_clk) disable iff (!rst_n)
      (req_valid && !overflow)
      |=> (precision_flag == $past(rnd.inexact) && roundup_wr
           && roundup_condition_bit == $past(rnd.rounded_up));
  endproperty
  a_status: assert property (p_status)
    else $error("Precision or round-up status is wrong.");

  property p_one_answer;
    @(posedge ref_clk) disable iff (!rst_n)
      done |-> $past(req_valid);
  endproperty
  a_one_answer: assert property (p_one_answer)
    else $error("Answer without a request.");

  // Main scenarios.
  c_masked:  cover property (@(posedge ref_clk) disable iff (!rst_n)
                             store_valid && invalid_operation_flag);
  c_trap:    cover property (@(posedge ref_clk) disable iff (!rst_n) trap);
  c_roundup: cover property (@(posedge ref_clk) disable iff (!rst_n)
                             roundup_condition_bit && precision_flag);
  c_wide:    cover property (@(posedge ref_clk) disable iff (!rst_n)
                             store_valid && store_width == DST_64);

endmodule : float_to_int_store
`default_nettype wire

// File: include/fist_pkg.sv
// Constants and types for the float-to-integer store unit.
// Assumes an 80-bit extended operand: sign, 15-bit exponent, 64-bit significand.
package fist_pkg;

  localparam int          SIG_W       = 64;
  localparam int          EXP_W       = 15;
  localparam logic [14:0] EXP_BIAS    = 15'h3fff;
  localparam logic [14:0] EXP_SPECIAL = 15'h7fff;
  localparam int          MAX_INT_EXP = 63;
  localparam int          LATENCY     = 1;

  // Rounding control in its usual two-bit encoding.
  typedef enum logic [1:0] {
    RND_NEAREST = 2'h0,
    RND_DOWN    = 2'h1,
    RND_UP      = 2'h2,
    RND_CHOP    = 2'h3
  } round_mode_type;

  // Destination integer width.
  typedef enum logic [1:0] {
    DST_16 = 2'h0,
    DST_32 = 2'h1,
    DST_64 = 2'h2
  } dest_width_type;

  // Largest positive magnitude for a width; negatives may reach one more.
  function automatic logic [64:0] pos_limit(input dest_width_type w);
    case (w)
      DST_16:  pos_limit = 65'h0_0000_0000_0000_7fff;
      DST_32:  pos_limit = 65'h0_0000_0000_7fff_ffff;
      default: pos_limit = 65'h0_7fff_ffff_ffff_ffff;
    endcase
  endfunction : pos_limit

  // Integer indefinite: only the sign position of the width is set.
  function automatic logic [63:0] indefinite(input dest_width_type w);
    case (w)
      DST_16:  indefinite = 64'h0000_0000_0000_8000;
      DST_32:  indefinite = 64'h0000_0000_8000_0000;
      default: indefinite = 64'h8000_0000_0000_0000;
    endcase
  endfunction : indefinite

  // Lane mask of the stored bits for a width.
  function automatic logic [63:0] width_mask(input dest_width_type w);
    case (w)
      DST_16:  width_mask = 64'h0000_0000_0000_ffff;
      DST_32:  width_mask = 64'h0000_0000_ffff_ffff;
      default: width_mask = 64'hffff_ffff_ffff_ffff;
    endcase
  endfunction : width_mask

endpackage : fist_pkg

// File: include/round_if.sv
// Carrier between the store unit and its align-and-round stage.
// Assumes both ends sit in the same clock domain; all signals are combinational.
`timescale 1ns/100ps
`default_nettype none
interface round_if;
  import fist_pkg::*;
  logic           sign;
  logic [14:0]    exponent;
  logic [63:0]    significand;
  round_mode_type mode;
  logic [64:0]    magnitude;
  logic           inexact;
  logic           rounded_up;
  logic           huge;

  modport rounder (input sign, exponent, significand, mode,
                   output magnitude, inexact, rounded_up, huge);
  modport user    (output sign, exponent, significand, mode,
                   input magnitude, inexact, rounded_up, huge);
endinterface : round_if
`default_nettype wire

// File: design/round_align.sv
// Align-and-round stage: turns an extended operand into a rounded integer magnitude.
// Assumes the caller applies the range check; this stage keeps the carry in bit 64.
`timescale 1ns/100ps
`default_nettype none
module round_align
  import fist_pkg::*;
(
  round_if.rounder rif
);

  logic signed [16:0] unb_exp;
  logic signed [16:0] shift_wide;
  logic        [6:0]  shamt;
  logic        [127:0] aligned;
  logic        [63:0] int_part;
  logic               round_bit;
  logic               sticky;
  logic               inc;

  // Shift the significand so the binary point sits at bit 64 of a 128-bit word.
  // Keeping the whole fraction avoids losing sticky bits on tiny exponents.
  always_comb begin
    unb_exp    = $signed({2'h0, rif.exponent}) - $signed({2'h0, EXP_BIAS});
    shift_wide = 17'sd63 - unb_exp;
    shamt      = shift_wide[6:0];
    aligned    = 128'h0;
    int_part   = 64'h0;
    round_bit  = 1'b0;
    sticky     = 1'b0;
    rif.huge   = (rif.exponent == EXP_SPECIAL) || (unb_exp > 17'sd63);
    if (!rif.huge && unb_exp >= -17'sd1) begin
      aligned   = {rif.significand, 64'h0} >> shamt;
      int_part  = aligned[127:64];
      round_bit = aligned[63];
      sticky    = |aligned[62:0];
    end else if (!rif.huge) begin
      sticky = |rif.significand;
    end
  end

  // Increment decision per mode; directed modes look at the sign.
  always_comb begin
    case (rif.mode)
      RND_NEAREST: inc = round_bit & (sticky | int_part[0]);
      RND_DOWN:    inc = rif.sign & (round_bit | sticky);
      RND_UP:      inc = ~rif.sign & (round_bit | sticky);
      default:     inc = 1'b0;
    endcase
  end

  // The 65-bit sum keeps the carry so an all-ones integer part never wraps to zero.
  assign rif.magnitude  = {1'b0, int_part} + {64'h0, inc};
  assign rif.inexact    = round_bit | sticky;
  assign rif.rounded_up = inc;

endmodule : round_align
`default_nettype wire

// File: tb/store_partner.sv
// Model of the memory write path and FP stack beside the store unit.
// Assumes the unit's answer pulses last one cycle and are sampled on ref_clk.
`timescale 1ns/100ps
`default_nettype none
module store_partner (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        store_valid,
  input  wire logic        keep_operand,
  input  wire logic [63:0] store_data,
  output logic [31:0]      n_stores,
  output logic [31:0]      n_kept,
  output logic [63:0]      last_word
);
  // Memory takes every offered word; a kept operand stays on the stack unpopped.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      n_stores  <= 32'h0;
      n_kept    <= 32'h0;
      last_word <= 64'h0;
    end else begin
      if (store_valid) begin
        n_stores  <= n_stores + 32'h1;
        last_word <= store_data;
      end
      if (keep_operand) n_kept <= n_kept + 32'h1;
    end
  end
endmodule : store_partner
`default_nettype wire

// File: tb/float_to_int_store_bench.sv
// Self-checking bench for the float-to-integer store unit.
// Assumes the one-cycle answer latency and one-cycle output pulses of the unit.
`timescale 1ns/100ps
`default_nettype none
module float_to_int_store_bench;
  import fist_pkg::*;
  typedef struct packed {
    logic dn, sv, keep, ivf, prc, rup, tr;
    logic [63:0] data;
    dest_width_type w;
  } expect_type;
  logic           ref_clk, rst_n, req_valid, op_sign, invalid_mask;
  logic [14:0]    op_exponent;
  logic [63:0]    op_significand, store_data, last_word, last_exp;
  round_mode_type round_mode;
  dest_width_type dest_width, store_width;
  logic           done, store_valid, keep_operand, invalid_operation_flag;
  logic           precision_flag, roundup_wr, roundup_condition_bit, trap;
  logic [31:0]    n_stores, n_kept, seed, r0, r1;
  int             n_fail, checks, st_exp, kp_exp;
  expect_type     pend;

  float_to_int_store DUT (.ref_clk, .rst_n, .req_valid, .op_sign, .op_exponent,
    .op_significand, .round_mode, .dest_width, .invalid_mask, .done, .store_valid,
    .store_data, .store_width, .keep_operand, .invalid_operation_flag,
    .precision_flag, .roundup_wr, .roundup_condition_bit, .trap);
  store_partner partner (.ref_clk, .rst_n, .store_valid, .keep_operand, .store_data,
    .n_stores, .n_kept, .last_word);

  // Free-running clock, 5 ns period.
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    xs = x ^ (x << 5);
  endfunction : xs

  // Reference conversion: shift into integer and fraction, round, then range-check.
  function automatic expect_type predict(input logic s, input logic [14:0] e,
    input logic [63:0] m, input round_mode_type md, input dest_width_type w, input logic mk);
    expect_type  r;
    logic [127:0] t;
    logic [64:0] mag, lim;
    logic        inc, inx, ovf;
    int          ue, sh;
    ue = int'(e) - int'(EXP_BIAS);
    sh = (63 - ue > 127) ? 127 : (ue > 63 ? 0 : 63 - ue);
    t = {m, 64'h0} >> sh;
    inx = |t[63:0];
    case (md)
      RND_NEAREST: inc = t[63] && (|t[62:0] || t[64]);
      RND_UP:      inc = inx && !s;
      RND_DOWN:    inc = inx && s;
      default:     inc = 1'b0;
    endcase
    mag = {1'b0, t[127:64]} + {64'h0, inc};
    lim = 65'h1 << ((w == DST_16) ? 15 : (w == DST_32) ? 31 : 63);
    ovf = (e == 15'h7fff) || (ue > 63) || (mag > lim - {64'h0, !s});
    r = '0;
    r.dn = 1'b1;
    r.w = w;
    if (ovf) begin
      r.ivf = 1'b1;
      r.sv = mk;
      r.keep = !mk;
      r.tr = !mk;
      r.data = mk ? lim[63:0] : 64'h0;
    end else begin
      r.sv = 1'b1;
      r.rup = inc;
      r.prc = inx;
      r.data = (s ? (65'h0 - mag) : mag) & ((lim << 1) - 65'h1);
    end
    return r;
  endfunction : predict

  task automatic cmp_word(input string nm, input logic [63:0] ex, input logic [63:0] got);
    checks++;
    if (got !== ex) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, ex, got);
    end
  endtask : cmp_word

  task automatic cmp_bit(input string nm, input logic ex, input logic got);
    cmp_word(nm, {63'h0, ex}, {63'h0, got});
  endtask : cmp_bit

  // Every output but store_width and roundup_condition_bit is compared every cycle, so a pulse that lingers is caught too.
  task automatic check_out();
    cmp_bit("done", pend.dn, done);
    cmp_bit("store_valid", pend.sv, store_valid);
    cmp_word("store_data", pend.data, store_data);
    if (pend.dn === 1'b1) cmp_word("store_width", 64'(pend.w), 64'(store_width));
    cmp_bit("keep_operand", pend.keep, keep_operand);
    cmp_bit("invalid_flag", pend.ivf, invalid_operation_flag);
    cmp_bit("trap", pend.tr, trap);
    cmp_bit("precision", pend.prc, precision_flag);
    cmp_bit("roundup_wr", pend.dn, roundup_wr);
    if (pend.dn === 1'b1) cmp_bit("roundup_bit", pend.rup, roundup_condition_bit);
  endtask : check_out

  // One cycle at the falling edge: check the last answer, then drive the next request.
  task automatic step(input logic v, input logic [79:0] op, input round_mode_type md,
    input dest_width_type w, input logic mk);
    check_out();
    req_valid = v;
    {op_sign, op_exponent, op_significand} = op;
    round_mode = md;
    dest_width = w;
    invalid_mask = mk;
    pend = v ? predict(op[79], op[78:64], op[63:0], md, w, mk) : '0;
    st_exp += int'(pend.sv);
    kp_exp += int'(pend.keep);
    if (pend.sv) last_exp = pend.data;
    @(negedge ref_clk);
  endtask : step

  function automatic logic [79:0] corner(input int k);
    case (k)
      0: corner = {1'b0, 15'h400e, 64'hffff_ffff_ffff_ffff};
      1: corner = {1'b0, 15'h400d, 64'hffff_0000_0000_0000};
      2: corner = {1'b1, 15'h400e, 64'h8001_0000_0000_0000};
      3: corner = {1'b0, 15'h401e, 64'hffff_ffff_ffff_ffff};
      4: corner = {1'b1, 15'h401e, 64'h8000_0000_8000_0000};
      5: corner = {1'b0, 15'h3ffb, 64'h8000_0000_0000_0000};
      default: corner = {1'b0, 15'h7fff, 64'h8000_0000_0000_0000};
    endcase
  endfunction : corner

  task automatic summarize();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize

  // A hang is cut short here and reported as a mismatch.
  initial begin
    repeat (100000) @(posedge ref_clk);
    n_fail++;
    summarize();
  end

  // Reset, corner table over every mode, width and mask, then random traffic.
  initial begin
    {n_fail, checks, st_exp, kp_exp} = 128'h0;
    seed = 32'h3cf7;
    pend = '0;
    last_exp = 64'h0;
    rst_n = 1'b0;
    req_valid = 1'b0;
    {op_sign, op_exponent, op_significand, invalid_mask} = 81'h0;
    round_mode = RND_NEAREST;
    dest_width = DST_16;
    repeat (5) @(negedge ref_clk);
    rst_n = 1'b1;
    step(1'b0, 80'h0, RND_NEAREST, DST_16, 1'b0);
    for (int k = 0; k < 7; k++)
      for (int md = 0; md < 4; md++)
        for (int w = 0; w < 3; w++)
          for (int mk = 0; mk < 2; mk++)
            step(1'b1, corner(k), round_mode_type'(md[1:0]), dest_width_type'(w[1:0]),
                 mk[0]);
    for (int i = 0; i < 3000; i++) begin
      seed = xs(seed);
      r0 = seed;
      seed = xs(seed);
      r1 = seed;
      step(r0[0] | r0[1], {r0[2], (r0[7:3] == 5'h0) ? 15'h7fff : EXP_BIAS - 15'h2
           + 15'(r0[31:8] % 70), (r0[12:11] == 2'h0) ? ~64'h0 << (r1 % 40) : {1'b1,
           r1, r0[31:1]}}, round_mode_type'(r0[14:13]), dest_width_type'(r0[16:15] % 3),
           r0[17]);
    end
    step(1'b0, 80'h0, RND_NEAREST, DST_16, 1'b0);
    cmp_word("memory_stores", 64'(st_exp), 64'(n_stores));
    cmp_word("kept_operands", 64'(kp_exp), 64'(n_kept));
    cmp_word("last_word", last_exp, last_word);
    summarize();
  end
endmodule : float_to_int_store_bench
`default_nettype wire
